// ==== rupp_top.sv ====
/*
  ram user program partition: one base register that places user
  program space inside the data ram, a status register, and a one-cycle
  classifier that tells which partition a ram access falls in.
  assumes: the user data base and ram size registers live elsewhere and
  arrive here as plain words; register port strobes are one cycle long
  and never overlap; all inputs are synchronous to core_clk.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rupp_regs.svh"

module rupp_top #(
  parameter int ADDR_W = 32 // width of the ram access offset
) (
  input wire logic core_clk, // system clock, 250 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [7:0] reg_addr, // register byte offset
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic [31:0] ram_user_data_base, // companion user data base
  input wire logic [31:0] ram_size_value, // ram size in bytes
  input wire logic acc_valid, // ram access to classify
  input wire logic [ADDR_W-1:0] acc_addr, // ram byte offset of the access
  input wire logic acc_user, // access made in user mode
  output logic acc_done, // classification result valid
  output rupp_pkg::rupp_region_t acc_region, // region of the access
  output logic acc_fault, // access not allowed for its mode
  output logic [31:0] user_prog_base, // program base as byte offset
  output logic user_prog_present // user program space exists
);

  // field must reach bit 15 of the offset; wider than a word is not served
  if (ADDR_W < (`RUPP_FIELD_MSB + 1) || ADDR_W > 32) begin : g_bad_width
    $error("rupp_top: ADDR_W must lie between 16 and 32");
  end

  // one offset compare shared by every register select
  function automatic logic offset_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // register decode
  wire sel_base = offset_hit(reg_addr, `RUPP_BASE_OFF);
  wire sel_status = offset_hit(reg_addr, `RUPP_STATUS_OFF);
  wire wr_base = reg_wr && sel_base;
  wire rd_base = reg_rd && sel_base;
  wire rd_status = reg_rd && sel_status;

  // only bits 15:10 of the write word are kept; the rest fall away
  wire rupp_pkg::rupp_field_t wr_field =
    reg_wdata[`RUPP_FIELD_MSB:`RUPP_FIELD_LSB];

  rupp_pkg::rupp_field_t base_field;

  rupp_base_reg u_base (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(wr_base),
    .load_value(wr_field),
    .field(base_field)
  );

  // base as a byte offset: low ten bits are forced zero
  wire [31:0] base_word = {`RUPP_HIGH_ZERO, base_field, `RUPP_LOW_ZERO};
  wire base_present = (base_field != `RUPP_FIELD_RESET);

  // consistency of software's programming, shown in status only;
  // the hardware does not refuse a bad value, it just reports it
  wire below_data = base_present && (base_word <= ram_user_data_base);
  wire above_size = base_present && (base_word > ram_size_value);

  // access classification
  wire [31:0] acc_offset = 32'(acc_addr);
  rupp_pkg::rupp_region_t next_region;

  rupp_region_decode u_decode (
    .offset(acc_offset),
    .prog_base(base_word), // zero field gives no program region
    .data_base(ram_user_data_base),
    .ram_size(ram_size_value),
    .region(next_region)
  );

  // user mode may touch user data and user program only;
  // nobody may go past the end of the ram
  wire next_fault = (next_region == rupp_pkg::RUPP_OUTSIDE) ||
    (acc_user && (next_region == rupp_pkg::RUPP_KERNEL));

  logic last_fault;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_done <= 1'b0;
      acc_region <= rupp_pkg::RUPP_KERNEL;
      acc_fault <= 1'b0;
    end else begin
      acc_done <= acc_valid;
      if (acc_valid) begin
        acc_region <= next_region;
        acc_fault <= next_fault;
      end
    end
  end

  // last classified access result, kept for status reads
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_fault <= 1'b0;
    end else if (acc_valid) begin
      last_fault <= next_fault;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      user_prog_base <= `RUPP_ZERO_WORD;
      user_prog_present <= 1'b0;
    end else begin
      user_prog_base <= base_word;
      user_prog_present <= base_present;
    end
  end

  // read data
  wire [31:0] status_word = {
    `RUPP_STATUS_FILL,
    last_fault,
    above_size,
    below_data,
    base_present
  };

  // unmapped offsets read zero, so do all cycles without a read
  wire [31:0] next_rdata = rd_base ? base_word :
    rd_status ? status_word : `RUPP_ZERO_WORD;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= `RUPP_ZERO_WORD;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // helper slices of the read data and region flags for the checks below
  wire rupp_pkg::rupp_field_t rd_field = reg_rdata[`RUPP_FIELD_MSB:`RUPP_FIELD_LSB];
  wire [`RUPP_FIELD_LSB-1:0] rd_low = reg_rdata[`RUPP_FIELD_LSB-1:0];
  wire [`RUPP_REG_MSB-`RUPP_FIELD_MSB-1:0] rd_high = reg_rdata[`RUPP_REG_MSB:`RUPP_FIELD_MSB+1];
  wire in_prog = (acc_offset >= base_word) && (acc_offset < ram_size_value);
  // region expectations worked out from the raw words, not from the decoder
  wire in_outside = (acc_offset >= ram_size_value);
  wire in_kernel = !in_outside &&
    (!base_present || (acc_offset < base_word)) &&
    ((ram_user_data_base == `RUPP_ZERO_WORD) || (acc_offset < ram_user_data_base));
  wire in_udata_only = !in_outside && !base_present &&
    (ram_user_data_base != `RUPP_ZERO_WORD) && (acc_offset >= ram_user_data_base);

  sequence s_base_write;
    wr_base;
  endsequence

  sequence s_write_then_read;
    wr_base ##1 rd_base;
  endsequence

  sequence s_write_idle;
    wr_base ##1 1'b1;
  endsequence

  sequence s_status_read;
    rd_status;
  endsequence

  sequence s_access;
    acc_valid;
  endsequence

  a_reset_clears_base: assert property (
    $rose(rst_n) |-> (base_field == `RUPP_FIELD_RESET) && !user_prog_present)
    else $error("base field not zero after reset");

  a_write_loads_field: assert property (
    s_base_write |=> (base_field == $past(wr_field)))
    else $error("base field did not take the written value");

  a_readback_field: assert property (
    s_write_then_read |=> (rd_field == $past(wr_field, 2)))
    else $error("read back differs from the written field");

  a_low_bits_zero: assert property (
    rd_base |=> (rd_low == `RUPP_LOW_ZERO))
    else $error("bits 9:0 of the base register read non-zero");

  a_upper_bits_zero: assert property (
    rd_base |=> (rd_high == `RUPP_HIGH_ZERO))
    else $error("bits 31:16 of the base register read non-zero");

  a_zero_no_prog: assert property (
    (acc_valid && !base_present) |=> (acc_region != rupp_pkg::RUPP_UPROG))
    else $error("user program region seen while the field is zero");

  a_prog_region_hit: assert property (
    (acc_valid && base_present && in_prog) |=>
      acc_done && (acc_region == rupp_pkg::RUPP_UPROG))
    else $error("access above the program base not sorted as user program");

  a_present_follows: assert property (
    s_write_idle |=> (user_prog_present == ($past(wr_field, 2) != `RUPP_FIELD_RESET)))
    else $error("program present flag does not follow the written field");

  a_status_present: assert property (
    rd_status |=> (reg_rdata[`RUPP_ST_PRESENT] == $past(base_present)))
    else $error("status present bit wrong");

  a_rdata_idle_zero: assert property (
    !reg_rd |=> (reg_rdata == `RUPP_ZERO_WORD))
    else $error("read data not zero outside a read");

  a_status_below: assert property (
    s_status_read |=> (reg_rdata[`RUPP_ST_BELOW_DATA] ==
      $past(base_present && (base_word <= ram_user_data_base))))
    else $error("status below-data bit wrong");

  a_status_above: assert property (
    s_status_read |=> (reg_rdata[`RUPP_ST_ABOVE_SIZE] ==
      $past(base_present && (base_word > ram_size_value))))
    else $error("status above-size bit wrong");

  a_status_fault: assert property (
    s_status_read |=> (reg_rdata[`RUPP_ST_LAST_FAULT] == $past(last_fault)))
    else $error("status fault bit wrong");

  a_status_pad_zero: assert property (
    s_status_read |=> (reg_rdata[`RUPP_REG_MSB:`RUPP_ST_PAD_LSB] == `RUPP_STATUS_FILL))
    else $error("unused status bits read non-zero");

  a_other_write_keeps: assert property (
    (reg_wr && !sel_base) |=> $stable(base_field))
    else $error("base field moved on a write to another offset");

  a_done_follows: assert property (
    s_access |=> acc_done)
    else $error("no result one cycle after an access");

  a_done_drops: assert property (
    !acc_valid |=> !acc_done)
    else $error("result flagged without an access");

  a_result_holds: assert property (
    !acc_valid |=> ($stable(acc_region) && $stable(acc_fault)))
    else $error("access result changed without an access");

  a_region_one_hot: assert property (
    $onehot(acc_region))
    else $error("access region not one-hot");

  a_outside_fault: assert property (
    (acc_valid && in_outside) |=>
      acc_fault && (acc_region == rupp_pkg::RUPP_OUTSIDE))
    else $error("access past the ram end not faulted");

  a_user_kernel_fault: assert property (
    (acc_valid && acc_user && in_kernel) |=>
      acc_fault && (acc_region == rupp_pkg::RUPP_KERNEL))
    else $error("user access to kernel data not faulted");

  a_kernel_mode_ok: assert property (
    (acc_valid && !acc_user && !in_outside) |=> !acc_fault)
    else $error("kernel access inside the ram faulted");

  a_udata_no_boundary: assert property (
    (acc_valid && in_udata_only) |=> (acc_region == rupp_pkg::RUPP_UDATA))
    else $error("zero field still drew a program boundary");

  a_base_out_follows: assert property (
    s_write_idle |=> (user_prog_base ==
      {`RUPP_HIGH_ZERO, $past(wr_field, 2), `RUPP_LOW_ZERO}))
    else $error("program base output does not follow the field");

  // sampled values at the release edge still show the reset state
  a_reset_outputs: assert property (
    $rose(rst_n) |-> (reg_rdata == `RUPP_ZERO_WORD) && !acc_done && !acc_fault &&
      (acc_region == rupp_pkg::RUPP_KERNEL) && (user_prog_base == `RUPP_ZERO_WORD))
    else $error("outputs not at reset values after reset");

endmodule // rupp_top

// ==== rupp_regs.svh ====
/*
  register offsets, field positions and reset values of the ram user
  program partition block.
  assumes: included by bare name from every design file that decodes them.
*/
`ifndef RUPP_REGS_SVH
`define RUPP_REGS_SVH

// register offsets on the plain register port
`define RUPP_BASE_OFF 8'h00
`define RUPP_STATUS_OFF 8'h04

// writable base field inside the base register
`define RUPP_FIELD_MSB 15
`define RUPP_FIELD_LSB 10
`define RUPP_FIELD_RESET 6'h00

// status register bit positions
`define RUPP_ST_PRESENT 0
`define RUPP_ST_BELOW_DATA 1
`define RUPP_ST_ABOVE_SIZE 2
`define RUPP_ST_LAST_FAULT 3
`define RUPP_ST_PAD_LSB 4

// constant fill values
`define RUPP_ZERO_WORD 32'h0000_0000
`define RUPP_LOW_ZERO 10'h000
// unused upper bits of the base and status registers
`define RUPP_REG_MSB 31
`define RUPP_HIGH_ZERO 16'h0000
`define RUPP_STATUS_FILL 28'h000_0000

`endif

// ==== rupp_pkg.sv ====
/*
  types shared by the ram user program partition block.
  assumes: compiled before every other file of the block.
*/
package rupp_pkg;

  // ram region that an access falls in, one-hot
  typedef enum logic [3:0] {
    RUPP_KERNEL  = 4'h1,
    RUPP_UDATA   = 4'h2,
    RUPP_UPROG   = 4'h4,
    RUPP_OUTSIDE = 4'h8
  } rupp_region_t;

  // width of the writable base field (1 KB granules)
  typedef logic [5:0] rupp_field_t;

endpackage

// ==== rupp_base_reg.sv ====
/*
  holder for the user program base field.
  assumes: load is a one-cycle strobe from the register decode.
*/
`timescale 1ns/1ps
`include "rupp_regs.svh"

module rupp_base_reg (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic load, // write strobe for the field
  input wire rupp_pkg::rupp_field_t load_value, // new field value
  output rupp_pkg::rupp_field_t field // stored field
);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      field <= `RUPP_FIELD_RESET;
    end else if (load) begin
      field <= load_value;
    end
  end

  a_field_hold_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !load |=> $stable(field))
    else $error("base field changed without a write");

endmodule // rupp_base_reg

// ==== rupp_region_decode.sv ====
/*
  combinational sorting of a ram offset into kernel data, user data,
  user program or outside the ram.
  assumes: all offsets are byte offsets relative to the ram start.
*/
`timescale 1ns/1ps
`include "rupp_regs.svh"

module rupp_region_decode (
  input wire logic [31:0] offset, // ram byte offset to sort
  input wire logic [31:0] prog_base, // user program base, zero if absent
  input wire logic [31:0] data_base, // user data base, zero if absent
  input wire logic [31:0] ram_size, // ram size in bytes
  output rupp_pkg::rupp_region_t region // one-hot region
);

  function automatic rupp_pkg::rupp_region_t classify(
    input logic [31:0] off,
    input logic [31:0] pbase,
    input logic [31:0] dbase,
    input logic [31:0] size
  );
    if (off >= size) begin
      return rupp_pkg::RUPP_OUTSIDE;
    end else if ((pbase != `RUPP_ZERO_WORD) && (off >= pbase)) begin
      return rupp_pkg::RUPP_UPROG;
    end else if ((dbase != `RUPP_ZERO_WORD) && (off >= dbase)) begin
      return rupp_pkg::RUPP_UDATA;
    end else begin
      return rupp_pkg::RUPP_KERNEL;
    end
  endfunction

  assign region = classify(offset, prog_base, data_base, ram_size);

endmodule // rupp_region_decode

// ==== rupp_top_tb.sv ====
/*
  self-checking bench for the ram user program partition top: register
  reads and writes, status flags, the access classifier and reset.
  assumes: rupp_pkg is compiled first; the design checks itself inline.
*/
`timescale 1ns/1ps

module rupp_top_tb;
  logic core_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] ram_user_data_base;
  logic [31:0] ram_size_value;
  logic acc_valid;
  logic [31:0] acc_addr;
  logic acc_user;
  logic acc_done;
  rupp_pkg::rupp_region_t acc_region;
  logic acc_fault;
  logic [31:0] user_prog_base;
  logic user_prog_present;
  int fails;
  int samples_checked;
  logic [5:0] f;
  logic [31:0] b;

  rupp_top uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ram_user_data_base(ram_user_data_base), .ram_size_value(ram_size_value),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_user(acc_user),
    .acc_done(acc_done), .acc_region(acc_region), .acc_fault(acc_fault),
    .user_prog_base(user_prog_base), .user_prog_present(user_prog_present));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic acc(input logic [31:0] a, input logic u, input logic [3:0] r,
                     input logic flt);
    @(posedge core_clk);
    acc_addr <= a;
    acc_user <= u;
    acc_valid <= 1'b1;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
    check({31'h0, acc_done}, 32'h1);
    check({28'h0, acc_region}, {28'h0, r});
    check({31'h0, acc_fault}, {31'h0, flt});
  endtask

  initial begin
    #20000;
    fails++;
    end_of_test();
  end

  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ram_user_data_base = 32'h0000_0800;
    ram_size_value = 32'h0000_2000;
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_user = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    check({31'h0, user_prog_present}, 32'h0);
    rd(8'h04, 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_fc00);
    check(user_prog_base, 32'h0000_fc00);
    rd(8'h04, 32'h5);
    // walking field bit, junk in the read-zero bits
    for (int i = 0; i < 6; i++) begin
      f = 6'h01 << i;
      b = {16'h0, f, 10'h0};
      wr_rd(8'h00, {16'hffff, f, 10'h3ff}, b);
      rd(8'h04, {29'h0, b > 32'h2000, b <= 32'h800, 1'b1});
    end
    wr(8'h08, 32'hffff_ffff);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'h0000_8000);
    $display("test field access done");
    wr(8'h00, 32'h0000_1000);
    acc(32'h1800, 1'b1, rupp_pkg::RUPP_UPROG, 1'b0);
    acc(32'h0100, 1'b1, rupp_pkg::RUPP_KERNEL, 1'b1);
    acc(32'h0100, 1'b0, rupp_pkg::RUPP_KERNEL, 1'b0);
    acc(32'h0900, 1'b1, rupp_pkg::RUPP_UDATA, 1'b0);
    acc(32'h3000, 1'b0, rupp_pkg::RUPP_OUTSIDE, 1'b1);
    rd(8'h04, 32'h9);
    $display("test classifier done");
    wr(8'h00, 32'h0000_0000);
    acc(32'h1800, 1'b1, rupp_pkg::RUPP_UDATA, 1'b0);
    check({31'h0, user_prog_present}, 32'h0);
    check(user_prog_base, 32'h0);
    $display("test zero field done");
    wr(8'h00, 32'h0000_2000);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    check({31'h0, user_prog_present}, 32'h0);
    acc(32'h1800, 1'b1, rupp_pkg::RUPP_UDATA, 1'b0);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule // rupp_top_tb
